// [src/i2c_link_params.svh]
/*
  constants of the two-wire register link: bank layout, address,
  reset values and timing counts.
  assumes a 125 MHz system clock on both ends.
*/
// Behaviour
// - address 01000 plus two select pins
// - bank of 128 byte-wide locations
// - 0..80 read/write, 96..127 read-only
// - master starts, sends address, write bit zero
// - data sampled on clock rising edge
// - ack on address match, else release
// - master samples ack on next rise
// - write: pointer byte then data bytes
// - every received byte acked on ninth rise
// - write pointer auto-increments per data byte
// - stop is data rising while clock high
// - read: address and pointer written first, acked
// - repeated start, read address, then data
// - master nacks last byte, then stops
// - clock at most 100 kbps standard
// - at least 1 us stop to start
`ifndef I2C_LINK_PARAMS_SVH
`define I2C_LINK_PARAMS_SVH
`define ADDR_FIXED 5'h08
`define RW_LAST 7'h50
`define RO_FIRST 7'h60
`define REG_RST 8'h00
`define STATUS_W 256
`define CLK_NS 8
`define T_QTR_NS 2500
`define QTR_CYC ((`T_QTR_NS + `CLK_NS - 1) / `CLK_NS)
`define T_MIN_NS 1000
`define MIN_CYC ((`T_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// [src/i2c_link_pkg.sv]
/*
  types shared by both ends of the two-wire register link.
  assumes nothing beyond a sv compiler.
*/
`default_nettype none
package i2c_link_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_RECV = 3'h1,
    S_RACK = 3'h3,
    S_SEND = 3'h2,
    S_SACK = 3'h6
  } dev_state_e;
  typedef enum logic [1:0] {
    K_ADDR = 2'h0,
    K_PTR = 2'h1,
    K_DATA = 2'h2
  } byte_kind_e;
  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_STOP = 2'h1,
    OP_WRITE = 2'h2,
    OP_READ = 2'h3
  } host_op_e;
  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_START = 2'h1,
    H_BYTE = 2'h3,
    H_STOP = 2'h2
  } host_state_e;
endpackage
`default_nettype wire

// [src/i2c_link_if.sv]
/*
  open-drain two-wire link between master and register device.
  assumes pull-ups: a line is high unless some end drives it low.
*/
`default_nettype none
interface i2c_link_if;
  logic scl_out;
  logic scl_oe_n;
  logic sda_m_out;
  logic sda_m_oe_n;
  logic sda_s_out;
  logic sda_s_oe_n;
  logic scl;
  logic sda;
  // wired-and of all drivers
  assign scl = scl_oe_n | scl_out;
  assign sda = (sda_m_oe_n | sda_m_out) & (sda_s_oe_n | sda_s_out);
  modport device (
    input scl,
    input sda,
    output sda_s_out,
    output sda_s_oe_n
  );
  modport host (
    input scl,
    input sda,
    output scl_out,
    output scl_oe_n,
    output sda_m_out,
    output sda_m_oe_n
  );
endinterface
`default_nettype wire

// [src/pin_sync.sv]
/*
  three-stage synchroniser with agreement filter for pin levels.
  assumes inputs asynchronous to CLOCK.
*/
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // pins and filtered levels
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] lv_q;
  if (W < 1) begin : g_bad_w
    $error("pin_sync width must be at least one");
  end
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      s1_q <= {W{RST_VAL}};
      s2_q <= {W{RST_VAL}};
      s3_q <= {W{RST_VAL}};
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge CLOCK) begin
        if (RST) begin
          lv_q[i] <= RST_VAL;
        end else if (s2_q[i] == s3_q[i]) begin
          lv_q[i] <= s3_q[i];
        end
      end
    end
  endgenerate
  assign level = lv_q;
endmodule
`default_nettype wire

// [src/i2c_reg_device.sv]
/*
  register device end of the two-wire link: 128-entry byte bank.
  assumes a master on the link and status bytes on STATUS_IN.
*/
`default_nettype none
`include "i2c_link_params.svh"
module i2c_reg_device (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // address select straps
  input wire logic ADDR_SELECT_LOW,
  input wire logic ADDR_SELECT_HIGH,
  // link
  i2c_link_if.device LINK,
  // read-only status, location 96 in bits 7:0
  input wire logic [`STATUS_W-1:0] STATUS_IN,
  // configuration read port
  input wire logic [6:0] CFG_RD_ADDR,
  output logic [7:0] CFG_RD_DATA,
  // write notification
  output logic WR_PULSE,
  output logic [6:0] WR_ADDR,
  output logic [7:0] WR_DATA
);
  logic [3:0] lv;
  logic scl_l;
  logic sda_l;
  logic scl_p_q;
  logic sda_p_q;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  i2c_link_pkg::dev_state_e st_q;
  i2c_link_pkg::byte_kind_e kind_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [6:0] ptr_q;
  logic rd_q;
  logic ack_ok_q;
  logic nack_q;
  logic sda_low_q;
  logic [7:0] byte_in;
  logic last_rise;
  logic wr_en;
  logic [7:0] regs [0:`RW_LAST];
  logic [7:0] rd_byte;

  function automatic logic is_rw(input logic [6:0] a);
    is_rw = (a <= `RW_LAST);
  endfunction

  function automatic logic [7:0] bank_read(input logic [6:0] a);
    if (is_rw(a)) begin
      bank_read = regs[a];
    end else if (a >= `RO_FIRST) begin
      bank_read = STATUS_IN[{a[4:0], 3'h0} +: 8];
    end else begin
      bank_read = 8'h00;
    end
  endfunction

  pin_sync #(
    .W(4),
    .RST_VAL(1'b1)
  ) u_sync (
    .CLOCK(CLOCK),
    .RST(RST),
    .pin_in({LINK.scl, LINK.sda, ADDR_SELECT_HIGH, ADDR_SELECT_LOW}),
    .level(lv)
  );
  assign scl_l = lv[3];
  assign sda_l = lv[2];

  // line history and conditions
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_l;
      sda_p_q <= sda_l;
    end
  end
  assign rise = scl_l & ~scl_p_q;
  assign fall = ~scl_l & scl_p_q;
  assign start = scl_l & scl_p_q & sda_p_q & ~sda_l;
  assign stop = scl_l & scl_p_q & ~sda_p_q & sda_l;

  assign byte_in = {sh_q[6:0], sda_l};
  assign last_rise = (st_q == i2c_link_pkg::S_RECV) && rise &&
    (cnt_q == 4'h7);
  assign wr_en = last_rise && (kind_q == i2c_link_pkg::K_DATA) &&
    is_rw(ptr_q);
  always_comb begin
    rd_byte = bank_read(ptr_q);
  end

  // protocol engine
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      st_q <= i2c_link_pkg::S_IDLE;
      kind_q <= i2c_link_pkg::K_ADDR;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 7'h00;
      rd_q <= 1'b0;
      ack_ok_q <= 1'b0;
      nack_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (start) begin
      st_q <= i2c_link_pkg::S_RECV;
      kind_q <= i2c_link_pkg::K_ADDR;
      cnt_q <= 4'h0;
      sda_low_q <= 1'b0;
    end else if (stop) begin
      st_q <= i2c_link_pkg::S_IDLE;
      sda_low_q <= 1'b0;
    end else begin
      unique case (st_q)
        i2c_link_pkg::S_IDLE: begin
          sda_low_q <= 1'b0;
        end
        i2c_link_pkg::S_RECV: begin
          if (rise && cnt_q != 4'h8) begin
            sh_q <= byte_in;
            cnt_q <= cnt_q + 4'h1;
          end
          if (last_rise) begin
            ack_ok_q <= 1'b1;
            unique case (kind_q)
              i2c_link_pkg::K_ADDR: begin
                ack_ok_q <= (byte_in[7:1] ==
                  {`ADDR_FIXED, lv[1:0]});
                rd_q <= byte_in[0];
                kind_q <= i2c_link_pkg::K_PTR;
              end
              i2c_link_pkg::K_PTR: begin
                ptr_q <= byte_in[6:0];
                kind_q <= i2c_link_pkg::K_DATA;
              end
              i2c_link_pkg::K_DATA: begin
                ptr_q <= ptr_q + 7'h1;
              end
              default: begin
                kind_q <= i2c_link_pkg::K_ADDR;
              end
            endcase
          end
          if (fall && cnt_q == 4'h8) begin
            if (ack_ok_q) begin
              st_q <= i2c_link_pkg::S_RACK;
              sda_low_q <= 1'b1;
            end else begin
              st_q <= i2c_link_pkg::S_IDLE;
            end
          end
        end
        i2c_link_pkg::S_RACK: begin
          if (fall) begin
            cnt_q <= 4'h0;
            if (rd_q) begin
              st_q <= i2c_link_pkg::S_SEND;
              sh_q <= rd_byte;
              sda_low_q <= ~rd_byte[7];
            end else begin
              st_q <= i2c_link_pkg::S_RECV;
              sda_low_q <= 1'b0;
            end
          end
        end
        i2c_link_pkg::S_SEND: begin
          if (rise) begin
            cnt_q <= cnt_q + 4'h1;
          end
          if (fall) begin
            if (cnt_q == 4'h8) begin
              st_q <= i2c_link_pkg::S_SACK;
              sda_low_q <= 1'b0;
              ptr_q <= ptr_q + 7'h1;
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
              sda_low_q <= ~sh_q[6];
            end
          end
        end
        i2c_link_pkg::S_SACK: begin
          if (rise) begin
            nack_q <= sda_l;
          end
          if (fall) begin
            cnt_q <= 4'h0;
            if (nack_q) begin
              st_q <= i2c_link_pkg::S_IDLE;
            end else begin
              st_q <= i2c_link_pkg::S_SEND;
              sh_q <= rd_byte;
              sda_low_q <= ~rd_byte[7];
            end
          end
        end
        default: begin
          st_q <= i2c_link_pkg::S_IDLE;
          sda_low_q <= 1'b0;
        end
      endcase
    end
  end

  // register bank storage
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      for (int i = 0; i <= `RW_LAST; i++) begin
        regs[i] <= `REG_RST;
      end
    end else if (wr_en) begin
      regs[ptr_q] <= byte_in;
    end
  end

  // write notification
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      WR_PULSE <= 1'b0;
      WR_ADDR <= 7'h00;
      WR_DATA <= 8'h00;
    end else begin
      WR_PULSE <= wr_en;
      if (wr_en) begin
        WR_ADDR <= ptr_q;
        WR_DATA <= byte_in;
      end
    end
  end

  // user read port
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      CFG_RD_DATA <= 8'h00;
    end else begin
      CFG_RD_DATA <= bank_read(CFG_RD_ADDR);
    end
  end

  assign LINK.sda_s_out = 1'b0;
  assign LINK.sda_s_oe_n = ~sda_low_q;
endmodule
`default_nettype wire

// [src/i2c_host.sv]
/*
  master end of the two-wire link: byte-level command engine.
  assumes the clock divider below meets the device's timing.
*/
`default_nettype none
`include "i2c_link_params.svh"
module i2c_host #(
  parameter int QTR = `QTR_CYC
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // command
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire i2c_link_pkg::host_op_e CMD_OP,
  input wire logic [7:0] CMD_DATA,
  input wire logic CMD_ACK,
  // result
  output logic DONE,
  output logic [7:0] RD_DATA,
  output logic ACK_SEEN,
  // link
  i2c_link_if.host LINK
);
  i2c_link_pkg::host_state_e st_q;
  logic [15:0] qc_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [8:0] tx_q;
  logic [8:0] rx_q;
  logic scl_low_q;
  logic sda_low_q;
  logic sda_l;
  logic tick;
  if (QTR < 1 || QTR > 65535) begin : g_bad_qtr
    $error("i2c_host quarter out of range");
  end
  if (2 * QTR < `MIN_CYC) begin : g_short_qtr
    $error("i2c_host quarter too short");
  end

  pin_sync #(
    .W(1),
    .RST_VAL(1'b1)
  ) u_sync (
    .CLOCK(CLOCK),
    .RST(RST),
    .pin_in(LINK.sda),
    .level(sda_l)
  );

  assign tick = (qc_q == 16'(QTR - 1));
  assign CMD_READY = (st_q == i2c_link_pkg::H_IDLE);

  // quarter-period divider
  always_ff @(posedge CLOCK) begin
    if (RST || st_q == i2c_link_pkg::H_IDLE || tick) begin
      qc_q <= 16'h0;
    end else begin
      qc_q <= qc_q + 16'h1;
    end
  end

  // bit sequencer
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      st_q <= i2c_link_pkg::H_IDLE;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      tx_q <= 9'h1ff;
      rx_q <= 9'h000;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      DONE <= 1'b0;
      RD_DATA <= 8'h00;
      ACK_SEEN <= 1'b0;
    end else begin
      DONE <= 1'b0;
      unique case (st_q)
        i2c_link_pkg::H_IDLE: begin
          ph_q <= 2'h0;
          bit_q <= 4'h0;
          if (CMD_VALID) begin
            unique case (CMD_OP)
              i2c_link_pkg::OP_START: begin
                st_q <= i2c_link_pkg::H_START;
                sda_low_q <= 1'b0;
              end
              i2c_link_pkg::OP_STOP: begin
                st_q <= i2c_link_pkg::H_STOP;
                sda_low_q <= 1'b1;
              end
              i2c_link_pkg::OP_WRITE: begin
                st_q <= i2c_link_pkg::H_BYTE;
                tx_q <= {CMD_DATA, 1'b1};
                sda_low_q <= ~CMD_DATA[7];
              end
              i2c_link_pkg::OP_READ: begin
                st_q <= i2c_link_pkg::H_BYTE;
                tx_q <= {8'hff, ~CMD_ACK};
                sda_low_q <= 1'b0;
              end
            endcase
          end
        end
        i2c_link_pkg::H_START: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            unique case (ph_q)
              2'h0: scl_low_q <= 1'b0;
              2'h1: sda_low_q <= 1'b1;
              2'h2: scl_low_q <= 1'b1;
              2'h3: begin
                st_q <= i2c_link_pkg::H_IDLE;
                DONE <= 1'b1;
              end
            endcase
          end
        end
        i2c_link_pkg::H_BYTE: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            unique case (ph_q)
              2'h0: scl_low_q <= 1'b0;
              2'h1: rx_q <= {rx_q[7:0], sda_l};
              2'h2: scl_low_q <= 1'b1;
              2'h3: begin
                if (bit_q == 4'h8) begin
                  st_q <= i2c_link_pkg::H_IDLE;
                  DONE <= 1'b1;
                  RD_DATA <= rx_q[8:1];
                  ACK_SEEN <= ~rx_q[0];
                  sda_low_q <= 1'b0;
                end else begin
                  bit_q <= bit_q + 4'h1;
                  tx_q <= {tx_q[7:0], 1'b1};
                  sda_low_q <= ~tx_q[7];
                end
              end
            endcase
          end
        end
        i2c_link_pkg::H_STOP: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            unique case (ph_q)
              2'h0: scl_low_q <= 1'b0;
              2'h1: sda_low_q <= 1'b0;
              2'h2: sda_low_q <= 1'b0;
              2'h3: begin
                st_q <= i2c_link_pkg::H_IDLE;
                DONE <= 1'b1;
              end
            endcase
          end
        end
      endcase
    end
  end

  assign LINK.scl_out = 1'b0;
  assign LINK.scl_oe_n = ~scl_low_q;
  assign LINK.sda_m_out = 1'b0;
  assign LINK.sda_m_oe_n = ~sda_low_q;
endmodule
`default_nettype wire

// [test/i2c_link_chk.sv]
/*
  assertions on the two-wire link between host and register device.
  assumes the bench instantiates it beside the link interface.
*/
`default_nettype none
`include "i2c_link_params.svh"
module i2c_link_chk (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // link lines and drivers
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_oe_n,
  input wire logic sda_m_oe_n,
  input wire logic sda_s_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MIN_T = `MIN_CYC;
  logic scl_p_q, sda_p_q, first_q, rd_q, ack_q;
  logic [3:0] bit_q;
  logic [4:0] lo_q;
  logic [8:0] hi_q, free_q;
  logic rise, start, stop;
  assign rise = scl & ~scl_p_q;
  assign start = scl & scl_p_q & sda_p_q & ~sda;
  assign stop = scl & scl_p_q & ~sda_p_q & sda;
  always_ff @(posedge CLOCK) begin
    scl_p_q <= RST | scl;
    sda_p_q <= RST | sda;
  end
  // bit position within a byte
  always_ff @(posedge CLOCK) begin
    if (RST || start) begin
      bit_q <= 4'h0;
    end else if (rise) begin
      bit_q <= (bit_q == 4'h9) ? 4'h1 : bit_q + 4'h1;
    end
  end
  // address byte, direction and its ack
  always_ff @(posedge CLOCK) begin
    if (RST || start) begin
      rd_q <= 1'b0;
      ack_q <= 1'b0;
    end else if (rise && first_q && bit_q == 4'h7) begin
      rd_q <= sda;
    end else if (rise && first_q && bit_q == 4'h8) begin
      ack_q <= ~sda;
    end
  end
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      first_q <= 1'b0;
    end else if (start) begin
      first_q <= 1'b1;
    end else if (rise && bit_q == 4'h8) begin
      first_q <= 1'b0;
    end
  end
  // phase lengths
  always_ff @(posedge CLOCK) begin
    lo_q <= (scl || RST) ? 5'h00 : lo_q + 5'(lo_q != 5'h1f);
    hi_q <= (!scl || RST) ? 9'h000 : hi_q + 9'(hi_q != 9'h1ff);
  end
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      free_q <= 9'h1ff;
    end else if (stop) begin
      free_q <= 9'h000;
    end else if (free_q != 9'h1ff) begin
      free_q <= free_q + 9'h001;
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  sequence nine_rise;
    $rose(scl) && bit_q == 4'h8;
  endsequence
  sequence wr_ack_slot;
    nine_rise ##0 (!first_q && !rd_q && ack_q);
  endsequence
  stable_high_a: assert property (
    scl && $past(scl) |-> $stable(sda_s_oe_n))
    else $error("device moved data while clock high");
  prompt_drive_a: assert property ($fell(sda_s_oe_n) |-> lo_q < 5'd20)
    else $error("device drove data late in low phase");
  ack_ninth_a: assert property (
    $rose(scl) && !sda_s_oe_n && !(rd_q && !first_q) |-> bit_q == 4'h8)
    else $error("device pulled data outside ack bit");
  read_release_a: assert property (
    nine_rise ##0 (rd_q && !first_q) |-> sda_s_oe_n)
    else $error("device held data in master ack bit");
  every_ack_a: assert property (wr_ack_slot |-> !sda)
    else $error("written byte not acked");
  stop_free_a: assert property (stop |-> sda_s_oe_n)
    else $error("device driving at stop");
  bus_gap_a: assert property (start |-> free_q >= 9'(MIN_T))
    else $error("start too soon after stop");
  scl_high_a: assert property ($fell(scl) |-> hi_q >= 9'(MIN_T))
    else $error("clock high phase too short");
  host_data_a: assert property (
    scl_oe_n && $past(scl_oe_n) && !start && !stop |-> $stable(sda_m_oe_n))
    else $error("master moved data while clock high");
endmodule
`default_nettype wire

// [test/i2c_slave_register_bank_tb.sv]
/*
  bench: host and register device joined by the link interface.
  assumes the host command port as the only stimulus of the link.
*/
`default_nettype none
`include "i2c_link_params.svh"
module i2c_slave_register_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] bytes_t [$];
  localparam int QTR = 63;
  localparam int WAIT_MAX = 40 * QTR + 50;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic sel_lo = 1'b0;
  logic sel_hi = 1'b0;
  logic [`STATUS_W-1:0] status = '0;
  logic [6:0] cfg_addr = 7'h00;
  logic [6:0] dev = 7'h20;
  logic [6:0] wr_addr;
  logic [7:0] cfg_data, rd_data, wr_data;
  logic wr_pulse, cmd_ready, done, ack_seen;
  logic cmd_valid = 1'b0;
  logic cmd_ack = 1'b0;
  logic [7:0] cmd_data = 8'h00;
  i2c_link_pkg::host_op_e cmd_op = i2c_link_pkg::OP_START;
  int errors = 0;
  int tests_run = 0;
  int pulses = 0;
  always #4 clock = ~clock;
  always @(posedge clock) begin
    if (wr_pulse === 1'b1) pulses++;
  end
  i2c_link_if link();
  i2c_reg_device i2c_reg_device_i (.CLOCK(clock), .RST(rst),
    .ADDR_SELECT_LOW(sel_lo), .ADDR_SELECT_HIGH(sel_hi), .LINK(link),
    .STATUS_IN(status), .CFG_RD_ADDR(cfg_addr), .CFG_RD_DATA(cfg_data),
    .WR_PULSE(wr_pulse), .WR_ADDR(wr_addr), .WR_DATA(wr_data));
  i2c_host #(.QTR(QTR)) i2c_host_i (.CLOCK(clock), .RST(rst),
    .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_OP(cmd_op),
    .CMD_DATA(cmd_data), .CMD_ACK(cmd_ack), .DONE(done),
    .RD_DATA(rd_data), .ACK_SEEN(ack_seen), .LINK(link));
  i2c_link_chk i2c_link_chk_i (.CLOCK(clock), .RST(rst), .scl(link.scl),
    .sda(link.sda), .scl_oe_n(link.scl_oe_n),
    .sda_m_oe_n(link.sda_m_oe_n), .sda_s_oe_n(link.sda_s_oe_n));
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang();
    errors++;
    $display("ERROR %0t: host handshake missing", $time);
    results();
  endtask
  task automatic cmd(input i2c_link_pkg::host_op_e op, input logic [7:0] d,
                     input logic a);
    int n;
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = d;
    cmd_ack = a;
    n = 0;
    while (cmd_ready !== 1'b1) begin
      n++;
      if (n > WAIT_MAX) hang();
      @(negedge clock);
    end
    @(negedge clock);
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1) begin
      n++;
      if (n > WAIT_MAX) hang();
      @(negedge clock);
    end
  endtask
  task automatic open_dev(input logic [6:0] a, input logic rw);
    cmd(i2c_link_pkg::OP_START, 8'h00, 1'b0);
    cmd(i2c_link_pkg::OP_WRITE, {a, rw}, 1'b0);
  endtask
  task automatic put(input logic [7:0] d, input logic exp_ack);
    cmd(i2c_link_pkg::OP_WRITE, d, 1'b0);
    chk({7'h00, ack_seen}, {7'h00, exp_ack});
  endtask
  task automatic wr_burst(input logic [6:0] ptr, input bytes_t d);
    open_dev(dev, 1'b0);
    chk({7'h00, ack_seen}, 8'h01);
    put({1'b0, ptr}, 1'b1);
    foreach (d[i]) put(d[i], 1'b1);
    cmd(i2c_link_pkg::OP_STOP, 8'h00, 1'b0);
  endtask
  task automatic rd_burst(input logic [6:0] ptr, input bytes_t exp);
    open_dev(dev, 1'b0);
    put({1'b0, ptr}, 1'b1);
    open_dev(dev, 1'b1);
    chk({7'h00, ack_seen}, 8'h01);
    foreach (exp[i]) begin
      cmd(i2c_link_pkg::OP_READ, 8'h00, i < exp.size() - 1);
      chk(rd_data, exp[i]);
    end
    cmd(i2c_link_pkg::OP_STOP, 8'h00, 1'b0);
  endtask
  initial begin
    for (int k = 0; k < 32; k++) begin
      status[8*k +: 8] = 8'h40 + 8'(k);
    end
    repeat (5) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    // every strap setting, one matching and one foreign address
    for (int s = 0; s < 4; s++) begin
      {sel_hi, sel_lo} = 2'(s);
      repeat (8) @(negedge clock);
      open_dev(7'h20 + 7'(s), 1'b0);
      chk({7'h00, ack_seen}, 8'h01);
      cmd(i2c_link_pkg::OP_STOP, 8'h00, 1'b0);
      open_dev(s[0] ? 7'h28 + 7'(s) : 7'h20 + 7'(s ^ 1), 1'b0);
      chk({7'h00, ack_seen}, 8'h00);
      cmd(i2c_link_pkg::OP_STOP, 8'h00, 1'b0);
    end
    dev = 7'h23;
    // burst across the end of the writable range
    wr_burst(7'h4f, '{8'ha5, 8'h3c, 8'h96});
    chk(8'(pulses), 8'h02);
    chk({1'b0, wr_addr}, 8'h50);
    chk(wr_data, 8'h3c);
    cfg_addr = 7'h4f;
    repeat (2) @(negedge clock);
    chk(cfg_data, 8'ha5);
    rd_burst(7'h4f, '{8'ha5, 8'h3c, 8'h00});
    // read-only top location, then wrap to location 0
    wr_burst(7'h7f, '{8'h11, 8'h22});
    chk(8'(pulses), 8'h03);
    chk({1'b0, wr_addr}, 8'h00);
    rd_burst(7'h7e, '{8'h5e, 8'h5f, 8'h22});
    cfg_addr = 7'h00;
    repeat (2) @(negedge clock);
    chk(cfg_data, 8'h22);
    // reset in mid-run clears the writable bank
    rst = 1'b1;
    repeat (5) @(negedge clock);
    rst = 1'b0;
    repeat (2) @(negedge clock);
    chk(cfg_data, 8'h00);
    chk({7'h00, ack_seen}, 8'h00);
    results();
  end
endmodule
`default_nettype wire
